/* File: rtl/aopc_pkg.sv */
// package for the converter output and power configuration register bank
package aopc_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_FILTER = 8'h2d;
  localparam logic [7:0] IDX_SHAPER = 8'h2e;
  localparam logic [7:0] IDX_OFFSET = 8'h3d;
  localparam logic [7:0] IDX_WORD_HI = 8'h3f;
  localparam logic [7:0] IDX_WORD_LO = 8'h40;
  localparam logic [7:0] IDX_IFACE = 8'h41;
  localparam logic [7:0] IDX_MODE_A = 8'h42;
  localparam logic [7:0] IDX_MODE_B = 8'h44;
  localparam logic [7:0] IDX_POWER = 8'h45;
  localparam logic [7:0] IDX_HIFREQ = 8'h4a;
  localparam logic [7:0] IDX_STATUS = 8'h4f;

  // ==========================================================
  // storage slots, their indices and writable bits
  localparam int NREG = 10;
  localparam int SLOT_FILTER = 0;
  localparam int SLOT_SHAPER = 1;
  localparam int SLOT_OFFSET = 2;
  localparam int SLOT_WORD_HI = 3;
  localparam int SLOT_WORD_LO = 4;
  localparam int SLOT_IFACE = 5;
  localparam int SLOT_MODE_A = 6;
  localparam int SLOT_MODE_B = 7;
  localparam int SLOT_POWER = 8;
  localparam int SLOT_HIFREQ = 9;
  localparam logic [7:0] SLOT_IDX [NREG] = '{
    IDX_FILTER, IDX_SHAPER, IDX_OFFSET, IDX_WORD_HI, IDX_WORD_LO,
    IDX_IFACE, IDX_MODE_A, IDX_MODE_B, IDX_POWER, IDX_HIFREQ};
  localparam logic [7:0] SLOT_MASK [NREG] = '{
    8'h7f, 8'h40, 8'h20, 8'h3f, 8'hf8,
    8'hf0, 8'h08, 8'h01, 8'he4, 8'h01};
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================
  // field positions
  localparam int BIT_SHAPER_ON = 6;
  localparam int BIT_OFFSET_ON = 5;
  localparam int WORD_HI_W = 6;
  localparam int WORD_LO_POS = 3;
  localparam int WORD_LO_W = 5;
  localparam int IFACE_POS = 6;
  localparam int PDRIVE_POS = 4;
  localparam int BIT_MODE_A = 3;
  localparam int BIT_MODE_B = 0;
  localparam int BIT_STANDBY = 7;
  localparam int BIT_CLK_DRIVE = 6;
  localparam int BIT_DATA_DRIVE = 5;
  localparam int BIT_POWER_OFF = 2;
  localparam int BIT_HIFREQ = 0;
  localparam logic [1:0] IFACE_DDR = 2'h0;
  localparam int FILTER_COUNT = 55;

  // status bits
  localparam int ST_STANDBY_WAKE = 0;
  localparam int ST_PDN_WAKE = 1;
  localparam int ST_READY = 2;
  localparam int ST_FILTER_ACT = 3;
  localparam int ST_CMOS = 4;

  // ==========================================================
  // timing
  localparam int CLK_KHZ = 20_000;
  localparam int STANDBY_WAKE_US = 50;
  localparam int PDN_WAKE_US = 100;
  localparam int STANDBY_WAKE_CYC = STANDBY_WAKE_US * CLK_KHZ / 1000;
  localparam int PDN_WAKE_CYC = PDN_WAKE_US * CLK_KHZ / 1000;
  localparam int SAMPLE_W = 11;

  // ==========================================================
  // configuration handed to the converter core
  typedef struct packed {
    logic [6:0] chb_shaper_filter_sel;
    logic chb_shaper_enable;
    logic offset_loop_on;
    logic cmos_select;
    logic [1:0] parallel_clock_drive;
    logic diff_clock_drive;
    logic data_drive;
    logic standby_all;
    logic full_power_off;
    logic mode_a;
    logic mode_b;
    logic chb_high_input_freq;
  } aopc_cfg_s;

endpackage : aopc_pkg

/* File: rtl/aopc_wake_timer.sv */
// wake-up timer that tracks a power-down control and its recovery time
`timescale 1ns/1ps
module aopc_wake_timer
  import aopc_pkg::*;
#(
  parameter int WAKE_CYC = 1000
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic down_in,
  output logic busy_out
);

  localparam int CW = $clog2(WAKE_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(WAKE_CYC - 1);

  typedef enum logic [2:0] {
    AOPC_ON = 3'b001,
    AOPC_DOWN = 3'b010,
    AOPC_WAKING = 3'b100
  } aopc_wake_e;

  aopc_wake_e state;
  logic [CW-1:0] count;

  // ==========================================================
  // state: a new power-down during wake restarts the sequence
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= AOPC_ON;
    end else begin
      unique case (state)
        AOPC_ON: begin
          if (down_in) state <= AOPC_DOWN;
        end
        AOPC_DOWN: begin
          if (!down_in) state <= AOPC_WAKING;
        end
        AOPC_WAKING: begin
          if (down_in) state <= AOPC_DOWN;
          else if (count == LAST) state <= AOPC_ON;
        end
        default: state <= AOPC_ON;
      endcase
    end
  end

  // wake counter, only runs while waking
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
    end else if (state == AOPC_WAKING && !down_in) begin
      count <= count + CW'(1);
    end else begin
      count <= '0;
    end
  end

  assign busy_out = (state != AOPC_ON);

endmodule : aopc_wake_timer

/* File: rtl/aopc_cfg_regs.sv */
// apb register bank for converter output, test word and power configuration
//
// How it works
// - a seven-bit field picks one of 55 channel b shaping filters, in force once shaping is on.
// - bit 6 at index 2eh switches channel b noise shaping on when one, off when zero.
// - bit 5 at index 3dh switches the offset correction loop on when one, off when zero.
// - index 3fh bits 5:0 hold test word bits 10:5, sent instead of samples when selected.
// - index 40h bits 7:3 hold test word bits 4:0, sent instead of converter samples.
// - index 45h bit 7 puts both channels in standby, with about 50 us to wake on clear.
// - index 45h bit 6 doubles the differential clock driver strength for 50 ohm loads.
// - index 45h bit 5 doubles all data driver strengths for 50 ohm loads.
// - index 45h bit 2 powers down channels, references and buffers, 100 us to recover.
// - every writable register reads as zero after reset until written.
// - index 4ah bit 0 turns on channel b high-frequency mode, zero keeps the default.
`timescale 1ns/1ps
module aopc_cfg_regs
  import aopc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int STANDBY_CYC = STANDBY_WAKE_CYC,
  parameter int PDN_CYC = PDN_WAKE_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic user_word_sel_in,
  input wire logic [SAMPLE_W-1:0] sample_in,
  output logic [SAMPLE_W-1:0] sample_out,
  output aopc_cfg_s cfg_out,
  output logic conv_ready_out
);

  // ==========================================================
  // bus decode
  logic setup;
  logic access;
  logic aligned;
  logic [7:0] index;
  logic upper_zero;
  logic [NREG-1:0] hit;
  logic hit_status;
  logic any_hit;
  logic wr_ok;

  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in;
  assign aligned = (paddr_in[1:0] == 2'h0);
  assign index = paddr_in[9:2];
  // anything above the index field must be zero to hit a register
  assign upper_zero = (paddr_in[ADDR_W-1:10] == '0);
  assign hit_status = aligned && upper_zero && (index == IDX_STATUS);
  assign any_hit = (|hit) || hit_status;
  // status is read only, and a write must carry the low byte lane
  assign wr_ok = (|hit) && pstrb_in[0];

  // ==========================================================
  // register storage, one slot per writable register
  logic [7:0] regs [NREG];

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_slot
      assign hit[g] = aligned && upper_zero && (index == SLOT_IDX[g]);

      // reserved bits never stored, so they always read zero
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
          regs[g] <= REG_RESET;
        end else if (access && pwrite_in && hit[g] && pstrb_in[0]) begin
          regs[g] <= pwdata_in[7:0] & SLOT_MASK[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // decoded fields
  logic [6:0] filter_sel;
  logic shaper_on;
  logic offset_on;
  logic [SAMPLE_W-1:0] user_word;
  logic [1:0] iface_code;
  logic [1:0] pclk_drive;
  logic mode_a;
  logic mode_b;
  logic standby_bit;
  logic clk_drive;
  logic data_drive;
  logic power_off_bit;
  logic hifreq;

  assign filter_sel = regs[SLOT_FILTER][6:0];
  assign shaper_on = regs[SLOT_SHAPER][BIT_SHAPER_ON];
  assign offset_on = regs[SLOT_OFFSET][BIT_OFFSET_ON];
  // upper and lower halves of the test word
  assign user_word = {
    regs[SLOT_WORD_HI][WORD_HI_W-1:0],
    regs[SLOT_WORD_LO][WORD_LO_POS +: WORD_LO_W]
  };
  assign iface_code = regs[SLOT_IFACE][IFACE_POS +: 2];
  assign pclk_drive = regs[SLOT_IFACE][PDRIVE_POS +: 2];
  assign mode_a = regs[SLOT_MODE_A][BIT_MODE_A];
  assign mode_b = regs[SLOT_MODE_B][BIT_MODE_B];
  assign standby_bit = regs[SLOT_POWER][BIT_STANDBY];
  assign clk_drive = regs[SLOT_POWER][BIT_CLK_DRIVE];
  assign data_drive = regs[SLOT_POWER][BIT_DATA_DRIVE];
  assign power_off_bit = regs[SLOT_POWER][BIT_POWER_OFF];
  assign hifreq = regs[SLOT_HIFREQ][BIT_HIFREQ];

  // ==========================================================
  // filter selection only matters with shaping on; codes beyond
  // the filter count are passed through but flagged not in force
  logic filter_in_range;
  logic filter_active;

  assign filter_in_range = (filter_sel < 7'(FILTER_COUNT));
  assign filter_active = shaper_on && filter_in_range;

  // ==========================================================
  // wake-up tracking for standby and full power-down
  logic standby_busy;
  logic pdn_busy;

  aopc_wake_timer #(
    .WAKE_CYC(STANDBY_CYC)
  ) u_standby_wake (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .down_in(standby_bit),
    .busy_out(standby_busy)
  );

  aopc_wake_timer #(
    .WAKE_CYC(PDN_CYC)
  ) u_pdn_wake (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .down_in(power_off_bit),
    .busy_out(pdn_busy)
  );

  // ==========================================================
  // configuration towards the core, registered so it changes cleanly
  aopc_cfg_s next_cfg;

  always_comb begin
    next_cfg = '0;
    // filter number is held off until shaping is on
    next_cfg.chb_shaper_filter_sel = shaper_on ? filter_sel : 7'h00;
    next_cfg.chb_shaper_enable = shaper_on;
    next_cfg.offset_loop_on = offset_on;
    next_cfg.cmos_select = (iface_code != IFACE_DDR);
    next_cfg.parallel_clock_drive = pclk_drive;
    next_cfg.diff_clock_drive = clk_drive;
    next_cfg.data_drive = data_drive;
    next_cfg.standby_all = standby_bit;
    next_cfg.full_power_off = power_off_bit;
    next_cfg.mode_a = mode_a;
    next_cfg.mode_b = mode_b;
    next_cfg.chb_high_input_freq = hifreq;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_out <= '0;
    end else begin
      cfg_out <= next_cfg;
    end
  end

  // ==========================================================
  // converter ready once neither power control nor its wake is pending
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_ready_out <= 1'b0;
    end else begin
      conv_ready_out <= !standby_busy && !pdn_busy;
    end
  end

  // ==========================================================
  // output sample path: test word replaces converter data when chosen;
  // buffers are off in full power-down so the bus is held at zero
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sample_out <= '0;
    end else if (power_off_bit) begin
      sample_out <= '0;
    end else if (user_word_sel_in) begin
      sample_out <= user_word;
    end else begin
      sample_out <= sample_in;
    end
  end

  // ==========================================================
  // status word showing the bank's own state
  logic [7:0] status;

  always_comb begin
    status = 8'h00;
    status[ST_STANDBY_WAKE] = standby_busy;
    status[ST_PDN_WAKE] = pdn_busy;
    status[ST_READY] = conv_ready_out;
    status[ST_FILTER_ACT] = filter_active;
    status[ST_CMOS] = cfg_out.cmos_select;
  end

  // ==========================================================
  // read mux
  logic [7:0] next_rbyte;

  always_comb begin
    next_rbyte = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) next_rbyte = regs[i];
    end
    if (hit_status) next_rbyte = status;
  end

  // ==========================================================
  // answer: data and error captured in the setup cycle so both come
  // from flops and are valid in the zero-wait access phase
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup) begin
      prdata_out <= pwrite_in ? 32'h0000_0000 : {24'h00_0000, next_rbyte};
    end
  end

  // unmapped, misaligned, status writes and lane-less writes all error
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pslverr_out <= 1'b0;
    end else if (setup) begin
      pslverr_out <= pwrite_in ? !wr_ok : !any_hit;
    end else if (!psel_in) begin
      pslverr_out <= 1'b0;
    end
  end

  // no wait states
  assign pready_out = 1'b1;

endmodule : aopc_cfg_regs

/* File: testbench/aopc_cfg_regs_assertions.sv */
// checker for the converter configuration register bank ports
`timescale 1ns/1ps
module aopc_cfg_regs_chk
  import aopc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int STANDBY_CYC = 8,
  parameter int PDN_CYC = 16
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic user_word_sel_in,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic [SAMPLE_W-1:0] sample_out,
  input wire aopc_cfg_s cfg_out,
  input wire logic conv_ready_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // write access that stores: strobe for byte 0 present
  logic wr;
  assign wr = psel_in && penable_in && pwrite_in && pstrb_in[0];
  // wake window ends follow the bound wake counts; keep them short in simulation
  localparam int STANDBY_HI = STANDBY_CYC;
  localparam int PDN_HI = PDN_CYC;
  a_filter_gate: assert property (!cfg_out.chb_shaper_enable |->
    cfg_out.chb_shaper_filter_sel == 7'h00) else $error("filter not forced off");
  a_shaper_on: assert property (wr && paddr_in == 12'h0b8 && pwdata_in[6] |->
    ##[1:2] cfg_out.chb_shaper_enable) else $error("shaper enable lost");
  a_offset_on: assert property (wr && paddr_in == 12'h0f4 && pwdata_in[5] |->
    ##[1:2] cfg_out.offset_loop_on) else $error("offset loop enable lost");
  a_rsvd_read: assert property (psel_in && penable_in && !pwrite_in &&
    paddr_in == 12'h114 |-> prdata_out[31:8] == 24'h0 && prdata_out[4:3] == 2'h0 &&
    prdata_out[1:0] == 2'h0) else $error("reserved bits read nonzero");
  a_sample_pass: assert property (!$past(rst_in) && !$past(user_word_sel_in) &&
    !$past(cfg_out.full_power_off) && !cfg_out.full_power_off |->
    sample_out == $past(sample_in)) else $error("samples not passed");
  a_pdn_quiet: assert property (cfg_out.full_power_off |->
    sample_out == 11'h000) else $error("output live in power off");
  a_iface_ddr: assert property (wr && paddr_in == 12'h104 && pwdata_in[7:6] == 2'h0 |->
    ##[1:2] !cfg_out.cmos_select) else $error("ddr code gave cmos");
  a_iface_cmos: assert property (wr && paddr_in == 12'h104 && pwdata_in[7:6] != 2'h0 |->
    ##[1:2] cfg_out.cmos_select) else $error("cmos code gave ddr");
  a_standby_gate: assert property (cfg_out.standby_all && $past(cfg_out.standby_all) |->
    !conv_ready_out) else $error("ready in standby");
  // a power-off cleared alongside stretches the wake, so leave that case to a_pdn_wake
  a_standby_wake: assert property ($fell(cfg_out.standby_all) &&
    !cfg_out.full_power_off && !$past(cfg_out.full_power_off) |->
    !conv_ready_out [*6] ##[1:STANDBY_HI] conv_ready_out)
    else $error("standby wake time wrong");
  a_pdn_wake: assert property ($fell(cfg_out.full_power_off) && !cfg_out.standby_all |->
    !conv_ready_out [*8] ##[1:PDN_HI] conv_ready_out) else $error("power off wake time wrong");
  a_drive_dbl: assert property (wr && paddr_in == 12'h114 && pwdata_in[6:5] == 2'h3 |->
    ##[1:2] cfg_out.diff_clock_drive && cfg_out.data_drive) else $error("drive lost");
  a_hifreq_on: assert property (wr && paddr_in == 12'h128 && pwdata_in[0] |->
    ##[1:2] cfg_out.chb_high_input_freq) else $error("high freq mode lost");
endmodule : aopc_cfg_regs_chk

bind aopc_cfg_regs aopc_cfg_regs_chk #(.ADDR_W(ADDR_W), .STANDBY_CYC(STANDBY_CYC),
  .PDN_CYC(PDN_CYC))
  u_aopc_cfg_regs_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .user_word_sel_in(user_word_sel_in), .sample_in(sample_in),
  .sample_out(sample_out), .cfg_out(cfg_out), .conv_ready_out(conv_ready_out));

/* File: testbench/aopc_cfg_regs_bench.sv */
// self-checking bench for the converter configuration register bank
`timescale 1ns/1ps
module aopc_cfg_regs_bench import aopc_pkg::*;;
  localparam int SC = 8;
  localparam int PC = 16;
  logic ref_clk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, rerr, sel = 1'b0, rdy;
  logic [10:0] smp = 11'h000, sout;
  aopc_cfg_s cfg;
  int fails = 0, checked = 0, cyc = 0, n;
  always #25 ref_clk_in = ~ref_clk_in;
  aopc_cfg_regs #(.ADDR_W(12), .STANDBY_CYC(SC), .PDN_CYC(PC)) u_aopc_cfg_regs (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .user_word_sel_in(sel), .sample_in(smp), .sample_out(sout), .cfg_out(cfg),
    .conv_ready_out(rdy));
  // ==========================================
  // helpers
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen at an edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do @(posedge ref_clk_in); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'h1);
  endtask : wr
  // cfg_out trails a stored write by one edge, so wait two
  task settle();
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask : settle
  task wait_rdy();
    n = 0;
    while (rdy !== 1'b1 && n < 200) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
  endtask : wait_rdy
  // ==========================================
  // scenarios
  task t_reset();
    for (int i = 0; i < NREG; i++) begin
      xfer(1'b0, {2'h0, SLOT_IDX[i], 2'h0}, 32'h0, 4'h0);
      chk("reset value", rdat, 32'h0);
    end
    chk("cfg at reset", 32'(cfg), 32'h0);
    $display("done reset");
  endtask : t_reset
  task t_mask();
    for (int i = 0; i < NREG; i++) begin
      wr({2'h0, SLOT_IDX[i], 2'h0}, 32'hffff_ffff);
      xfer(1'b0, {2'h0, SLOT_IDX[i], 2'h0}, 32'h0, 4'h0);
      chk("write mask", rdat, {24'h0, SLOT_MASK[i]});
      wr({2'h0, SLOT_IDX[i], 2'h0}, 32'h0);
    end
    xfer(1'b0, 12'h0b0, 32'h0, 4'h0);
    chk("unmapped err", 32'(rerr), 32'h1);
    $display("done mask");
  endtask : t_mask
  task t_fields();
    wr(12'h0b4, 32'h36);
    wr(12'h0b8, 32'h40);
    settle();
    chk("filter", 32'(cfg.chb_shaper_filter_sel), 32'h36);
    chk("shaper", 32'(cfg.chb_shaper_enable), 32'h1);
    // status shows whether the chosen filter is really in force
    xfer(1'b0, 12'h13c, 32'h0, 4'h0);
    chk("filter in force", 32'(rdat[ST_FILTER_ACT]), 32'h1);
    wr(12'h0b4, 32'h37);
    xfer(1'b0, 12'h13c, 32'h0, 4'h0);
    chk("filter past end", 32'(rdat[ST_FILTER_ACT]), 32'h0);
    wr(12'h0b8, 32'h0);
    wr(12'h0f4, 32'h20);
    settle();
    chk("filter off", 32'(cfg.chb_shaper_filter_sel), 32'h0);
    chk("offset", 32'(cfg.offset_loop_on), 32'h1);
    for (int c = 0; c < 4; c++) begin
      wr(12'h104, 32'({2'(c), 2'(c), 4'h0}));
      settle();
      chk("cmos", 32'(cfg.cmos_select), 32'(c != 0));
      chk("clk drive", 32'(cfg.parallel_clock_drive), 32'(c));
    end
    wr(12'h114, 32'h60);
    wr(12'h128, 32'h1);
    wr(12'h108, 32'h8);
    wr(12'h110, 32'h1);
    settle();
    chk("diff drive", 32'(cfg.diff_clock_drive), 32'h1);
    chk("data drive", 32'(cfg.data_drive), 32'h1);
    chk("hifreq", 32'(cfg.chb_high_input_freq), 32'h1);
    chk("modes", 32'({cfg.mode_a, cfg.mode_b}), 32'h3);
    $display("done fields");
  endtask : t_fields
  task t_word();
    wr(12'h0fc, 32'h2a);
    wr(12'h100, 32'hb8);
    xfer(1'b1, 12'h0fc, 32'h15, 4'h0);
    chk("strobe err", 32'(rerr), 32'h1);
    @(posedge ref_clk_in);
    sel <= 1'b1;
    smp <= 11'h123;
    settle();
    chk("test word", 32'(sout), 32'({6'h2a, 5'h17}));
    @(posedge ref_clk_in);
    sel <= 1'b0;
    settle();
    chk("samples", 32'(sout), 32'h123);
    $display("done word");
  endtask : t_word
  task t_power();
    wr(12'h114, 32'h80);
    settle();
    chk("standby", 32'(rdy), 32'h0);
    xfer(1'b0, 12'h13c, 32'h0, 4'h0);
    chk("standby flag", 32'(rdat[ST_STANDBY_WAKE]), 32'h1);
    wr(12'h114, 32'h0);
    wait_rdy();
    chk("standby wake", 32'(n >= SC && n <= SC + 4), 32'h1);
    wr(12'h114, 32'h4);
    settle();
    chk("pdn out", 32'(sout), 32'h0);
    wr(12'h114, 32'h0);
    wait_rdy();
    chk("pdn wake", 32'(n >= PC && n <= PC + 4), 32'h1);
    $display("done power");
  endtask : t_power
  // ==========================================
  // verdict and hang guard
  task summarize();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_mask();
    t_fields();
    t_word();
    t_power();
    summarize();
  end
endmodule : aopc_cfg_regs_bench
